// ### timer_aux_control_regs.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module timer_aux_control_regs
  import timer_aux_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer side
  input  wire logic        hoco_freq_option,
  input  wire logic        hoco_tick,
  input  wire logic [1:0]  count_src_tick,
  input  wire logic [1:0]  ext_count_clock_pin,
  input  wire logic        aux_clock_source,
  input  wire logic [1:0]  input_capture_mode,
  input  wire logic        count_down,
  input  wire logic [7:0]  compare_match,
  input  wire logic        cutoff_interrupt_pin,
  input  wire logic [1:0]  event_link_in,
  input  wire logic [1:0]  channel_event,
  output var  logic [1:0]  filter_clk_en,
  output var  logic [7:0]  filter_enable,
  output var  logic [3:0]  b_pin_cutoff_ctl,
  output var  logic [1:0]  ext_count_en,
  output var  logic        ad_trigger,
  output var  logic [1:0]  event_capture_select,
  output var  logic        pulse_cutoff,
  output var  logic [3:0]  buffer_mode_select,
  output var  logic [5:0]  pwm_pin_select,
  output var  logic        channel_sync,
  output var  logic        irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] function_control;
  logic [7:0] filter_and_cutoff_control [2];
  logic [7:0] mode_reg, pwm_mode_reg, event_link_reg, ad_trigger_select_reg, count_source_reg;
  logic [1:0] aux_clock_select;
  logic [2:0] irq_status, irq_mask;
  logic       int_pin_cutoff_enable, cutoff_status_flag;

  logic [7:0] aw_addr, w_data, wr_data_eff, rd_byte;
  logic       aw_full, w_full, w_strb0, wr_fire, rd_fire, status_read;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == OFS_FUNCTION_CONTROL) || (a == OFS_FILTER_CUTOFF_0) ||
                 (a == OFS_FILTER_CUTOFF_1) || (a == OFS_MODE) ||
                 (a == OFS_PWM_MODE) || (a == OFS_OUTPUT_CUTOFF) ||
                 (a == OFS_EVENT_LINK) || (a == OFS_AD_TRIGGER_SELECT) ||
                 (a == OFS_EXT_CLOCK_SELECT) || (a == OFS_COUNT_SOURCE) ||
                 (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction : addr_known

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are held independently so either order works.
  assign wr_fire     = aw_full && w_full && !s_axi_bvalid;
  assign wr_data_eff = w_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_full       <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_full       <= 1'b0;
      w_data       <= 8'h00;
      w_strb0      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata[7:0];
      w_strb0      <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; other lanes are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      function_control             <= REG_RESET;
      filter_and_cutoff_control[0] <= REG_RESET;
      filter_and_cutoff_control[1] <= REG_RESET;
      mode_reg                     <= REG_RESET;
      pwm_mode_reg                 <= REG_RESET;
      int_pin_cutoff_enable        <= 1'b0;
      event_link_reg               <= REG_RESET;
      ad_trigger_select_reg        <= REG_RESET;
      aux_clock_select             <= 2'h0;
      count_source_reg             <= REG_RESET;
      irq_mask                     <= 3'h0;
    end else if (wr_fire && w_strb0) begin
      if (aw_addr == OFS_FUNCTION_CONTROL) begin
        function_control <= wr_data_eff;
      end else if (aw_addr == OFS_FILTER_CUTOFF_0) begin
        filter_and_cutoff_control[0] <= wr_data_eff;
      end else if (aw_addr == OFS_FILTER_CUTOFF_1) begin
        filter_and_cutoff_control[1] <= wr_data_eff;
      end else if (aw_addr == OFS_MODE) begin
        mode_reg <= wr_data_eff & 8'hF1;
      end else if (aw_addr == OFS_PWM_MODE) begin
        pwm_mode_reg <= wr_data_eff & 8'h77;
      end else if (aw_addr == OFS_OUTPUT_CUTOFF) begin
        int_pin_cutoff_enable <= wr_data_eff[OC_INT_PIN_ENABLE];
      end else if (aw_addr == OFS_EVENT_LINK) begin
        event_link_reg <= wr_data_eff & 8'h33;
      end else if (aw_addr == OFS_AD_TRIGGER_SELECT) begin
        ad_trigger_select_reg <= wr_data_eff;
      end else if (aw_addr == OFS_EXT_CLOCK_SELECT) begin
        aux_clock_select <= wr_data_eff[1:0];
      end else if (aw_addr == OFS_COUNT_SOURCE) begin
        count_source_reg <= wr_data_eff & 8'h77;
      end else if (aw_addr == OFS_IRQ_MASK) begin
        irq_mask <= wr_data_eff[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Forced cutoff
  // ----------------------------------------------------------------
  logic cutoff_req;

  assign cutoff_req = (int_pin_cutoff_enable && cutoff_interrupt_pin) ||
                      (|(event_link_in & {event_link_reg[5], event_link_reg[1]}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cutoff <= 1'b0;
    end else begin
      pulse_cutoff <= cutoff_req;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cutoff_status_flag <= 1'b0;
    end else if (cutoff_req) begin
      cutoff_status_flag <= 1'b1;
    end else if (wr_fire && w_strb0 && aw_addr == OFS_OUTPUT_CUTOFF &&
                 !wr_data_eff[OC_STATUS]) begin
      cutoff_status_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [2:0] next_irq_status, irq_events;

  assign irq_events  = {cutoff_req, channel_event};
  assign status_read = rd_fire && (s_axi_araddr == OFS_IRQ_STATUS);

  always_comb begin
    next_irq_status = status_read ? 3'h0 : irq_status;
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_byte = 8'h00;
    if (s_axi_araddr == OFS_FUNCTION_CONTROL) begin
      rd_byte = function_control;
    end else if (s_axi_araddr == OFS_FILTER_CUTOFF_0) begin
      rd_byte = filter_and_cutoff_control[0];
    end else if (s_axi_araddr == OFS_FILTER_CUTOFF_1) begin
      rd_byte = filter_and_cutoff_control[1];
    end else if (s_axi_araddr == OFS_MODE) begin
      rd_byte = mode_reg;
    end else if (s_axi_araddr == OFS_PWM_MODE) begin
      rd_byte = pwm_mode_reg;
    end else if (s_axi_araddr == OFS_OUTPUT_CUTOFF) begin
      rd_byte = {int_pin_cutoff_enable, 6'h00, cutoff_status_flag};
    end else if (s_axi_araddr == OFS_EVENT_LINK) begin
      rd_byte = event_link_reg;
    end else if (s_axi_araddr == OFS_AD_TRIGGER_SELECT) begin
      rd_byte = ad_trigger_select_reg;
    end else if (s_axi_araddr == OFS_EXT_CLOCK_SELECT) begin
      rd_byte = {6'h00, aux_clock_select};
    end else if (s_axi_araddr == OFS_COUNT_SOURCE) begin
      rd_byte = count_source_reg;
    end else if (s_axi_araddr == OFS_IRQ_STATUS) begin
      rd_byte = {5'h00, irq_status};
    end else if (s_axi_araddr == OFS_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Filter clock dividers
  // ----------------------------------------------------------------
  // Two dividers so a switch of the option bit never shortens a period
  // of the other source; the cost is a second 5-bit counter.
  logic [4:0] sys_div, hoco_div;
  logic       tick_div32, tick_div8, tick_div1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div <= 5'h00;
    end else begin
      sys_div <= sys_div + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hoco_div <= 5'h00;
    end else if (hoco_tick) begin
      hoco_div <= hoco_div + 5'h01;
    end
  end

  always_comb begin
    if (hoco_freq_option) begin
      tick_div1  = hoco_tick;
      tick_div8  = hoco_tick && (hoco_div[2:0] == DIV8_LAST);
      tick_div32 = hoco_tick && (hoco_div == DIV32_LAST);
    end else begin
      tick_div1  = 1'b1;
      tick_div8  = (sys_div[2:0] == DIV8_LAST);
      tick_div32 = (sys_div == DIV32_LAST);
    end
  end

  // ----------------------------------------------------------------
  // Per-channel outputs
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_channel
      logic [1:0] fsel;
      logic       ext_sel, src_tick;

      assign fsel    = {filter_and_cutoff_control[ch][FD_SEL_HI],
                        filter_and_cutoff_control[ch][FD_SEL_LO]};
      assign ext_sel = (count_source_reg[4*ch +: 3] == CSRC_EXTERNAL);
      // Auxiliary clock replaces the pin when its select bit is set
      assign src_tick = aux_clock_select[ch] ? aux_clock_source
                                             : ext_count_clock_pin[ch];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          filter_clk_en[ch] <= 1'b0;
        end else if (fsel == FCLK_DIV32) begin
          filter_clk_en[ch] <= tick_div32;
        end else if (fsel == FCLK_DIV8) begin
          filter_clk_en[ch] <= tick_div8;
        end else if (fsel == FCLK_DIV1) begin
          filter_clk_en[ch] <= tick_div1;
        end else begin
          filter_clk_en[ch] <= count_src_tick[ch];
        end
      end

      // The pin path is refused in three-phase mode, the aux path is not
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ext_count_en[ch] <= 1'b0;
        end else begin
          ext_count_en[ch] <= ext_sel && src_tick && (aux_clock_select[ch] ||
                              !function_control[FC_THREE_PHASE]);
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          filter_enable[4*ch +: 4]        <= 4'h0;
          b_pin_cutoff_ctl[2*ch +: 2]     <= 2'h0;
          event_capture_select[ch]        <= 1'b0;
          buffer_mode_select[2*ch +: 2]   <= 2'h0;
          pwm_pin_select[3*ch +: 3]       <= 3'h0;
        end else begin
          filter_enable[4*ch +: 4]        <= filter_and_cutoff_control[ch][3:0];
          b_pin_cutoff_ctl[2*ch +: 2]     <= {filter_and_cutoff_control[ch][FD_CUTOFF_CTL1],
                                              filter_and_cutoff_control[ch][FD_CUTOFF_CTL0]};
          event_capture_select[ch]        <= event_link_reg[4*ch];
          buffer_mode_select[2*ch +: 2]   <= mode_reg[4 + 2*ch +: 2];
          pwm_pin_select[3*ch +: 3]       <= pwm_mode_reg[4*ch +: 3];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_sync <= 1'b0;
    end else begin
      channel_sync <= mode_reg[MODE_SYNC];
    end
  end

  // ----------------------------------------------------------------
  // A/D conversion trigger
  // ----------------------------------------------------------------
  // Capture channels mask their own compare enables.
  logic [7:0] ad_match;
  logic       complementary, edge_ok;

  assign ad_match = compare_match & ad_trigger_select_reg &
                    ~{{4{input_capture_mode[1]}}, {4{input_capture_mode[0]}}};
  assign complementary = function_control[FC_CMD_COMPLEMENTARY];
  assign edge_ok = function_control[FC_AD_TRIGGER_EDGE] == count_down;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_trigger <= 1'b0;
    end else if (complementary) begin
      ad_trigger <= (|ad_match) && function_control[FC_AD_TRIGGER_ENABLE] && edge_ok;
    end else begin
      ad_trigger <= |ad_match;
    end
  end

endmodule : timer_aux_control_regs
`default_nettype wire

// ### timer_aux_control_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module timer_aux_control_regs_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic [7:0] compare_match,
  input wire logic [1:0] input_capture_mode,
  input wire logic       ad_trigger,
  input wire logic       cutoff_interrupt_pin,
  input wire logic [1:0] event_link_in,
  input wire logic       pulse_cutoff,
  input wire logic [1:0] ext_count_clock_pin,
  input wire logic       aux_clock_source,
  input wire logic [1:0] ext_count_en,
  input wire logic       hoco_freq_option,
  input wire logic       hoco_tick,
  input wire logic [1:0] count_src_tick,
  input wire logic [1:0] filter_clk_en,
  input wire logic [7:0] filter_enable,
  input wire logic [3:0] b_pin_cutoff_ctl,
  input wire logic [3:0] buffer_mode_select,
  input wire logic [5:0] pwm_pin_select,
  input wire logic       channel_sync,
  input wire logic       irq
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cutoff_cause_a: assert property (
    pulse_cutoff |-> $past(cutoff_interrupt_pin || (|event_link_in)))
    else $error("cutoff without a request");
  ad_cause_a: assert property (
    ad_trigger |-> $past(|(compare_match & ~{{4{input_capture_mode[1]}},
                                             {4{input_capture_mode[0]}}})))
    else $error("a/d trigger without a usable compare match");
  ext_cause_a: assert property (
    ext_count_en[0] |-> $past(ext_count_clock_pin[0] || aux_clock_source))
    else $error("external count enable without a tick");
  hoco_filter_a: assert property (
    filter_clk_en[0] && $past(hoco_freq_option) |-> $past(hoco_tick || count_src_tick[0]))
    else $error("filter clock not from oscillator");
  reset_clear_a: assert property (
    $rose(aresetn) |-> !irq && !pulse_cutoff && filter_enable == 8'h00 && !channel_sync)
    else $error("outputs not cleared by reset");
  pin_cutoff_hold_a: assert property (
    $changed(b_pin_cutoff_ctl) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin cutoff control changed without a write");
  buffer_hold_a: assert property (
    $changed(buffer_mode_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("buffer select changed without a write");
  pwm_hold_a: assert property (
    $changed(pwm_pin_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pwm select changed without a write");
  sync_hold_a: assert property (
    $changed(channel_sync) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("sync bit changed without a write");
endmodule : timer_aux_control_regs_props
bind timer_aux_control_regs timer_aux_control_regs_props props_i (.aclk, .aresetn,
  .s_axi_bvalid, .compare_match, .input_capture_mode, .ad_trigger, .cutoff_interrupt_pin,
  .event_link_in, .pulse_cutoff, .ext_count_clock_pin, .aux_clock_source, .ext_count_en,
  .hoco_freq_option, .hoco_tick, .count_src_tick, .filter_clk_en, .filter_enable,
  .b_pin_cutoff_ctl, .buffer_mode_select, .pwm_pin_select, .channel_sync, .irq);
`default_nettype wire

// ### timer_aux_control_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module timer_aux_control_regs_test;
  import timer_aux_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, hoco_freq_option, hoco_tick, aux_clock_source, count_down;
  logic        cutoff_interrupt_pin, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, ad_trigger, pulse_cutoff, channel_sync, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, compare_match, filter_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, b_pin_cutoff_ctl, buffer_mode_select;
  logic [1:0]  count_src_tick, ext_count_clock_pin, input_capture_mode, event_link_in;
  logic [1:0]  channel_event, s_axi_bresp, s_axi_rresp, filter_clk_en, ext_count_en;
  logic [1:0]  event_capture_select, cyc;
  logic [5:0]  pwm_pin_select;
  logic [7:0]  sh[12];
  int          errors, check_count, n_fce, n_ad, n_ext, n_cut, c;
  logic [7:0]  a, d;

  timer_aux_control_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hoco_freq_option, .hoco_tick, .count_src_tick,
    .ext_count_clock_pin, .aux_clock_source, .input_capture_mode, .count_down, .compare_match,
    .cutoff_interrupt_pin, .event_link_in, .channel_event, .filter_clk_en, .filter_enable,
    .b_pin_cutoff_ctl, .ext_count_en, .ad_trigger, .event_capture_select, .pulse_cutoff,
    .buffer_mode_select, .pwm_pin_select, .channel_sync, .irq);

  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 2'h1;
    hoco_tick <= (cyc == 2'h3);
    count_src_tick <= {2{cyc == 2'h1}};
  end
  // Counted on the falling edge, where outputs have settled
  always @(negedge aclk) begin
    n_fce += $countones(filter_clk_en);
    n_ad += ad_trigger;
    n_ext += $countones(ext_count_en);
    n_cut += pulse_cutoff;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] ad, dt, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, r});
  endtask : wr
  task automatic rd(input logic [7:0] ad, dt, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    chk(s_axi_rdata, {24'h000000, dt});
    chk({s_axi_rvalid, s_axi_rresp}, {1'b1, r});
  endtask : rd
  task automatic reset_dut;
    aresetn <= 1'b0;
    tick(16);
    aresetn <= 1'b1;
    sh = '{default: 8'h00};
  endtask : reset_dut
  function automatic logic [7:0] rmask(input logic [7:0] ad);
    case (ad)
      OFS_MODE: return 8'hF1;
      OFS_PWM_MODE, OFS_COUNT_SOURCE: return 8'h77;
      OFS_EVENT_LINK: return 8'h33;
      OFS_EXT_CLOCK_SELECT: return 8'h03;
      OFS_IRQ_MASK: return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction : rmask
  task automatic adt(input logic [7:0] f, input logic dn, ic, input logic [7:0] m, input int e);
    wr(OFS_FUNCTION_CONTROL, f, RESP_OKAY);
    count_down <= dn;
    input_capture_mode <= {1'b0, ic};
    c = n_ad;
    compare_match <= m;
    @(posedge aclk);
    compare_match <= 8'h00;
    tick(3);
    chk(n_ad - c, e);
  endtask : adt
  task automatic cut(input logic p, input logic [1:0] e, input int x);
    c = n_cut;
    cutoff_interrupt_pin <= p;
    event_link_in <= e;
    @(posedge aclk);
    cutoff_interrupt_pin <= 1'b0;
    event_link_in <= 2'h0;
    tick(3);
    chk(n_cut - c, x);
  endtask : cut
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid,
     hoco_freq_option, hoco_tick, aux_clock_source, count_down, cutoff_interrupt_pin,
     s_axi_awaddr, s_axi_araddr, compare_match, s_axi_wdata, count_src_tick, cyc,
     ext_count_clock_pin, input_capture_mode, event_link_in, channel_event} = '0;
    {errors, check_count, n_fce, n_ad, n_ext, n_cut} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
    c = $urandom(63823);
    reset_dut();
    for (int i = 0; i < 12; i++) rd(8'(i * 4), 8'h00, RESP_OKAY);
    wr(8'h30, 8'hFF, RESP_SLVERR);
    rd(8'h30, 8'h00, RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(OFS_MODE, 8'hFF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFS_MODE, 8'h00, RESP_OKAY);
    $display("reset and unmapped test done");
    for (int i = 0; i < 24; i++) begin
      a = 8'(4 * (1 + $urandom % 9));
      if (a == OFS_OUTPUT_CUTOFF) a = OFS_IRQ_MASK;
      d = 8'($urandom);
      wr(a, d, RESP_OKAY);
      sh[a >> 2] = d & rmask(a);
      rd(a, sh[a >> 2], RESP_OKAY);
      tick(2);
      chk(filter_enable, {sh[2][3:0], sh[1][3:0]});
      chk(b_pin_cutoff_ctl, {sh[2][5:4], sh[1][5:4]});
      chk(buffer_mode_select, sh[3][7:4]);
      chk(pwm_pin_select, {sh[4][6:4], sh[4][2:0]});
      chk(channel_sync, sh[3][0]);
      chk(event_capture_select, {sh[6][4], sh[6][0]});
    end
    $display("random register test done");
    reset_dut();
    for (int i = 0; i < 5; i++) begin
      hoco_freq_option <= (i == 4);
      d = (i == 4) ? 8'h80 : 8'(i << 6);
      wr(OFS_FILTER_CUTOFF_0, d, RESP_OKAY);
      wr(OFS_FILTER_CUTOFF_1, d, RESP_OKAY);
      tick(4);
      c = n_fce;
      tick(64);
      chk(n_fce - c, 2 * ((i == 0) ? 2 : (i == 1) ? 8 : (i == 2) ? 64 : 16));
    end
    hoco_freq_option <= 1'b0;
    $display("filter clock test done");
    wr(OFS_AD_TRIGGER_SELECT, 8'h01, RESP_OKAY);
    adt(8'h12, 1'b0, 1'b0, 8'h01, 1);
    adt(8'h12, 1'b1, 1'b0, 8'h01, 0);
    adt(8'h32, 1'b1, 1'b0, 8'h01, 1);
    adt(8'h02, 1'b0, 1'b0, 8'h01, 0);
    adt(8'h12, 1'b0, 1'b1, 8'h01, 0);
    adt(8'h00, 1'b0, 1'b0, 8'h01, 1);
    adt(8'h00, 1'b0, 1'b1, 8'h01, 0);
    adt(8'h12, 1'b0, 1'b0, 8'h02, 0);
    $display("a/d trigger test done");
    wr(OFS_COUNT_SOURCE, 8'h55, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_EXT_CLOCK_SELECT, {6'h00, {2{i[0]}}}, RESP_OKAY);
      wr(OFS_FUNCTION_CONTROL, {i[1], 7'h00}, RESP_OKAY);
      c = n_ext;
      ext_count_clock_pin <= {2{i != 3}};
      aux_clock_source <= (i == 3);
      @(posedge aclk);
      ext_count_clock_pin <= 2'h0;
      aux_clock_source <= 1'b0;
      tick(3);
      chk(n_ext - c, (i == 0 || i == 3) ? 2 : 0);
    end
    $display("count source test done");
    reset_dut();
    wr(OFS_IRQ_MASK, 8'h04, RESP_OKAY);
    wr(OFS_OUTPUT_CUTOFF, 8'h80, RESP_OKAY);
    cut(1'b1, 2'h0, 1);
    chk(irq, 1'b1);
    rd(OFS_OUTPUT_CUTOFF, 8'h81, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 8'h04, RESP_OKAY);
    tick(2);
    chk(irq, 1'b0);
    wr(OFS_OUTPUT_CUTOFF, 8'h00, RESP_OKAY);
    rd(OFS_OUTPUT_CUTOFF, 8'h00, RESP_OKAY);
    cut(1'b1, 2'h1, 0);
    wr(OFS_EVENT_LINK, 8'h02, RESP_OKAY);
    wr(OFS_IRQ_MASK, 8'h00, RESP_OKAY);
    cut(1'b0, 2'h1, 1);
    channel_event <= 2'h3;
    @(posedge aclk);
    channel_event <= 2'h0;
    tick(3);
    chk(irq, 1'b0);
    rd(OFS_IRQ_STATUS, 8'h07, RESP_OKAY);
    $display("cutoff and interrupt test done");
    results();
  end
endmodule : timer_aux_control_regs_test
`default_nettype wire

// ### timer_aux_pkg.sv
package timer_aux_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FUNCTION_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_FILTER_CUTOFF_0     = 8'h04;
  localparam logic [7:0] OFS_FILTER_CUTOFF_1     = 8'h08;
  localparam logic [7:0] OFS_MODE                = 8'h0C;
  localparam logic [7:0] OFS_PWM_MODE            = 8'h10;
  localparam logic [7:0] OFS_OUTPUT_CUTOFF       = 8'h14;
  localparam logic [7:0] OFS_EVENT_LINK          = 8'h18;
  localparam logic [7:0] OFS_AD_TRIGGER_SELECT   = 8'h1C;
  localparam logic [7:0] OFS_EXT_CLOCK_SELECT    = 8'h20;
  localparam logic [7:0] OFS_COUNT_SOURCE        = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS          = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK            = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FC_AD_TRIGGER_ENABLE  = 4;
  localparam int FC_AD_TRIGGER_EDGE    = 5;
  localparam int FC_THREE_PHASE        = 7;
  localparam int FC_CMD_COMPLEMENTARY  = 1;
  localparam int FD_SEL_HI             = 7;
  localparam int FD_SEL_LO             = 6;
  localparam int FD_CUTOFF_CTL1        = 5;
  localparam int FD_CUTOFF_CTL0        = 4;
  localparam int MODE_SYNC             = 0;
  localparam int OC_STATUS             = 0;
  localparam int OC_INT_PIN_ENABLE     = 7;
  localparam int IRQ_CUTOFF            = 2;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] FCLK_DIV32      = 2'h0;
  localparam logic [1:0] FCLK_DIV8       = 2'h1;
  localparam logic [1:0] FCLK_DIV1       = 2'h2;
  localparam logic [2:0] CSRC_EXTERNAL   = 3'h5;
  localparam logic [4:0] DIV32_LAST      = 5'h1F;
  localparam logic [2:0] DIV8_LAST       = 3'h7;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage : timer_aux_pkg
